//--- hw/svi_irq_unit.sv
// Six-source vectored interrupt controller with its two control registers
`timescale 1ns/1ns
module svi_irq_unit (
	input  wire logic       mclk,             // System clock, 50 MHz
	input  wire logic       reset,            // Synchronous reset, active high
	input  wire logic       phase_two_pulse,  // Core sampling phase, one cycle per instruction
	input  wire logic       ext_irq_pin_zero, // External pin 0, falling edge requests
	input  wire logic       ext_irq_pin_one,  // External pin 1, falling edge requests
	input  wire logic       tmr0_overflow,    // Timer 0 overflow pulse
	input  wire logic       tmr1_overflow,    // Timer 1 overflow pulse
	input  wire logic       tick_base_pulse,  // Periodic time base pulse
	input  wire logic       clock_tick_pulse, // Real time clock pulse
	input  wire logic       stack_full,       // Call stack has no free level
	input  wire logic       isr_exit_reenable,    // Interrupt return executes
	input  wire logic       plain_subroutine_exit, // Plain return executes
	input  wire logic [7:0] reg_addr,         // Data memory address
	input  wire logic [7:0] reg_wdata,        // Write data
	input  wire logic       reg_wr,           // Write strobe
	output logic [7:0]      reg_rdata,        // Registered read data
	output logic            irq_ack,          // One-cycle acknowledge: push PC, branch
	output logic [7:0]      irq_vector,       // Vector held from acknowledge
	output logic            global_irq_enable // Global enable state
);
	logic [7:0] prim_q;
	logic [7:0] prim_d;
	logic [7:0] sec_q;
	logic [7:0] sec_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       ack_q;
	logic       ack_d;
	logic [7:0] vec_q;
	logic [7:0] vec_d;
	logic [5:0] pend_q;
	logic [5:0] pend_d;
	logic       ext0_fall;
	logic       ext1_fall;
	logic [5:0] hw_set;
	logic [5:0] flags;
	logic [5:0] enables;
	logic [5:0] eligible;
	logic [5:0] grant;
	logic [7:0] grant_vec;
	logic       wr_prim;
	logic       wr_sec;

	// Pins come from outside the clock domain
	svi_pin_sync u_sync0 (
		.mclk       (mclk),
		.reset      (reset),
		.pin_n      (ext_irq_pin_zero),
		.fall_pulse (ext0_fall)
	);
	svi_pin_sync u_sync1 (
		.mclk       (mclk),
		.reset      (reset),
		.pin_n      (ext_irq_pin_one),
		.fall_pulse (ext1_fall)
	);

	// Source order is priority order, index 0 highest
	always_comb begin
		hw_set = {clock_tick_pulse, tick_base_pulse, tmr1_overflow,
			tmr0_overflow, ext1_fall, ext0_fall};
		flags = {sec_q[svi_pkg::BIT_RTC_FLAG], sec_q[svi_pkg::BIT_TBASE_FLAG],
			sec_q[svi_pkg::BIT_TMR1_FLAG], prim_q[svi_pkg::BIT_TMR0_FLAG],
			prim_q[svi_pkg::BIT_EXT1_FLAG], prim_q[svi_pkg::BIT_EXT0_FLAG]};
		enables = {sec_q[svi_pkg::BIT_RTC_EN], sec_q[svi_pkg::BIT_TBASE_EN],
			sec_q[svi_pkg::BIT_TMR1_EN], prim_q[svi_pkg::BIT_TMR0_EN],
			prim_q[svi_pkg::BIT_EXT1_EN], prim_q[svi_pkg::BIT_EXT0_EN]};
	end

	// Eligibility: flag, enable, global enable, stack room
	always_comb begin
		eligible = flags & enables;
		if (!prim_q[svi_pkg::BIT_GLOBAL_EN] || stack_full) begin
			eligible = 6'h00;
		end
	end

	// Fixed priority pick, lowest index wins
	always_comb begin
		grant     = 6'h00;
		grant_vec = svi_pkg::VEC_EXT0;
		if (pend_q[0]) begin
			grant[0]  = 1'b1;
			grant_vec = svi_pkg::VEC_EXT0;
		end else if (pend_q[1]) begin
			grant[1]  = 1'b1;
			grant_vec = svi_pkg::VEC_EXT1;
		end else if (pend_q[2]) begin
			grant[2]  = 1'b1;
			grant_vec = svi_pkg::VEC_TMR0;
		end else if (pend_q[3]) begin
			grant[3]  = 1'b1;
			grant_vec = svi_pkg::VEC_TMR1;
		end else if (pend_q[4]) begin
			grant[4]  = 1'b1;
			grant_vec = svi_pkg::VEC_TBASE;
		end else if (pend_q[5]) begin
			grant[5]  = 1'b1;
			grant_vec = svi_pkg::VEC_RTC;
		end
	end

	// Sample on phase two, acknowledge on the next one: one instruction of latency
	always_comb begin
		pend_d = pend_q;
		ack_d  = 1'b0;
		vec_d  = vec_q;
		if (phase_two_pulse) begin
			pend_d = 6'h00;
			// Winner must still be eligible from the registered masks, so a same-cycle mask write loses
			if (|(grant & eligible)) begin
				ack_d = 1'b1;
				vec_d = grant_vec;
			end else begin
				pend_d = eligible;
			end
		end
		// Mask changes in between drop stale samples
		pend_d = pend_d & eligible;
	end

	// Register update: hardware set beats software clear
	always_comb begin
		wr_prim = reg_wr && (reg_addr == svi_pkg::ADDR_PRIMARY);
		wr_sec  = reg_wr && (reg_addr == svi_pkg::ADDR_SECONDARY);
		prim_d  = prim_q;
		sec_d   = sec_q;
		if (wr_prim) begin
			prim_d = reg_wdata & svi_pkg::MASK_PRIMARY;
		end
		if (wr_sec) begin
			sec_d = reg_wdata & svi_pkg::MASK_SECONDARY;
		end
		// Acknowledge clears the winning flag and the global enable
		if (ack_d) begin
			prim_d[svi_pkg::BIT_GLOBAL_EN] = 1'b0;
			if (grant[0]) prim_d[svi_pkg::BIT_EXT0_FLAG] = 1'b0;
			if (grant[1]) prim_d[svi_pkg::BIT_EXT1_FLAG] = 1'b0;
			if (grant[2]) prim_d[svi_pkg::BIT_TMR0_FLAG] = 1'b0;
			if (grant[3]) sec_d[svi_pkg::BIT_TMR1_FLAG]  = 1'b0;
			if (grant[4]) sec_d[svi_pkg::BIT_TBASE_FLAG] = 1'b0;
			if (grant[5]) sec_d[svi_pkg::BIT_RTC_FLAG]   = 1'b0;
		end
		// Interrupt return re-enables; plain return does nothing here
		if (isr_exit_reenable && !ack_d) begin
			prim_d[svi_pkg::BIT_GLOBAL_EN] = 1'b1;
		end
		// Flags stick until serviced or cleared; events win over clears
		if (hw_set[0]) prim_d[svi_pkg::BIT_EXT0_FLAG] = 1'b1;
		if (hw_set[1]) prim_d[svi_pkg::BIT_EXT1_FLAG] = 1'b1;
		if (hw_set[2]) prim_d[svi_pkg::BIT_TMR0_FLAG] = 1'b1;
		if (hw_set[3]) sec_d[svi_pkg::BIT_TMR1_FLAG]  = 1'b1;
		if (hw_set[4]) sec_d[svi_pkg::BIT_TBASE_FLAG] = 1'b1;
		if (hw_set[5]) sec_d[svi_pkg::BIT_RTC_FLAG]   = 1'b1;
	end

	// Read mux, registered; unmapped addresses return zero
	always_comb begin
		case (reg_addr)
			svi_pkg::ADDR_PRIMARY: begin
				rdata_d = prim_d & svi_pkg::MASK_PRIMARY;
			end
			svi_pkg::ADDR_SECONDARY: begin
				rdata_d = sec_d & svi_pkg::MASK_SECONDARY;
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// State registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			prim_q  <= svi_pkg::RESET_PRIMARY;
			sec_q   <= svi_pkg::RESET_SECONDARY;
			rdata_q <= 8'h00;
			ack_q   <= 1'b0;
			vec_q   <= 8'h00;
			pend_q  <= 6'h00;
		end else begin
			prim_q  <= prim_d;
			sec_q   <= sec_d;
			rdata_q <= rdata_d;
			ack_q   <= ack_d;
			vec_q   <= vec_d;
			pend_q  <= pend_d;
		end
	end

	assign reg_rdata         = rdata_q;
	assign irq_ack           = ack_q;
	assign irq_vector        = vec_q;
	assign global_irq_enable = prim_q[svi_pkg::BIT_GLOBAL_EN];
endmodule

//--- hw/svi_pkg.sv
// Constants shared by the six-source vectored interrupt unit
//
// Contract
// - Timer 0 overflow sets primary bit 6; enabled, stack free gives vector 0CH.
// - Acknowledge clears the serviced flag and the global enable.
// - Timer 1 flag is secondary bit 4, vector 10H, else like timer 0.
// - Time base pulse sets secondary bit 5; enabled, stack free gives vector 14H.
// - Clock tick sets secondary bit 6; enabled, stack free gives vector 18H.
// - Further acknowledges held until interrupt return or software re-enables.
// - Interrupt return sets global enable; plain return leaves it alone.
// - Requests sampled once per instruction cycle, serviced on next phase-two pulse.
// - Fixed priority: ext0, ext1, timer0, timer1, time base, clock tick.
// - Global enable low masks every source.
// - Primary register 0BH: enable bit 0, enables 1-3, flags 4-6, bit 7 zero.
// - Secondary register 1EH: enables 0-2, flags 4-6, bits 3 and 7 zero.
// - A flag stays set until serviced or cleared by software.
// - Disabled source never serviced though its flag still records requests.
// - Time base and clock tick keep requesting while the core is halted.
// - Falling edge on external pins sets primary bit 4 or 5; vectors 04H, 08H.
// - No acknowledge while the call stack is full.
// - Acknowledge pushes only the program counter, then branches to the vector.
package svi_pkg;
	localparam logic [7:0] ADDR_PRIMARY   = 8'h0B;
	localparam logic [7:0] ADDR_SECONDARY = 8'h1E;
	// Primary register fields
	localparam int BIT_GLOBAL_EN = 0;
	localparam int BIT_EXT0_EN   = 1;
	localparam int BIT_EXT1_EN   = 2;
	localparam int BIT_TMR0_EN   = 3;
	localparam int BIT_EXT0_FLAG = 4;
	localparam int BIT_EXT1_FLAG = 5;
	localparam int BIT_TMR0_FLAG = 6;
	// Secondary register fields
	localparam int BIT_TMR1_EN   = 0;
	localparam int BIT_TBASE_EN  = 1;
	localparam int BIT_RTC_EN    = 2;
	localparam int BIT_TMR1_FLAG = 4;
	localparam int BIT_TBASE_FLAG = 5;
	localparam int BIT_RTC_FLAG  = 6;
	// Writable bit masks, unused bits read zero
	localparam logic [7:0] MASK_PRIMARY   = 8'h7F;
	localparam logic [7:0] MASK_SECONDARY = 8'h77;
	localparam logic [7:0] RESET_PRIMARY   = 8'h00;
	localparam logic [7:0] RESET_SECONDARY = 8'h00;
	// Vectors in priority order
	localparam logic [7:0] VEC_EXT0  = 8'h04;
	localparam logic [7:0] VEC_EXT1  = 8'h08;
	localparam logic [7:0] VEC_TMR0  = 8'h0C;
	localparam logic [7:0] VEC_TMR1  = 8'h10;
	localparam logic [7:0] VEC_TBASE = 8'h14;
	localparam logic [7:0] VEC_RTC   = 8'h18;
	localparam int NUM_SRC = 6;
	localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage

//--- hw/svi_pin_sync.sv
// Two-stage synchroniser with falling-edge detect for one external pin
`timescale 1ns/1ns
module svi_pin_sync (
	input  wire logic mclk,      // System clock
	input  wire logic reset,     // Synchronous reset, active high
	input  wire logic pin_n,     // Asynchronous pin, active low edge
	output logic      fall_pulse // One-cycle pulse on high-to-low
);
	logic [2:0] sh_q;
	logic [2:0] sh_d;
	logic       fall_q;
	logic       fall_d;

	// Stage 0 feeds only stage 1; edge logic looks at stages 1 and 2
	always_comb begin
		sh_d   = {sh_q[1:0], pin_n};
		fall_d = sh_q[2] & ~sh_q[1];
	end

	// Reset to all-high would be nicer but a constant zero is safe: no edge seen
	always_ff @(posedge mclk) begin
		if (reset) begin
			sh_q   <= svi_pkg::SYNC_RESET;
			fall_q <= 1'b0;
		end else begin
			sh_q   <= sh_d;
			fall_q <= fall_d & ~reset;
		end
	end

	assign fall_pulse = fall_q;
endmodule

//--- tb/svi_irq_unit_checker.sv
// Assertions on the ports of the vectored interrupt unit
`timescale 1ns/1ns
module svi_irq_checker (
	input wire logic       mclk,              // Clock
	input wire logic       reset,             // Sync reset
	input wire logic       phase_two_pulse,   // Sampling phase
	input wire logic       stack_full,        // No free level
	input wire logic       isr_exit_reenable, // Interrupt return
	input wire logic       reg_wr,            // Write strobe
	input wire logic [7:0] reg_addr,          // Address
	input wire logic [7:0] reg_rdata,         // Read data
	input wire logic       irq_ack,           // Acknowledge
	input wire logic [7:0] irq_vector,        // Vector
	input wire logic       global_irq_enable  // Global enable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Acknowledge shape and its causes
	chk_ack_pulse: assert property (irq_ack |=> !irq_ack) else $error("long ack");
	chk_ack_mask: assert property (irq_ack |-> !global_irq_enable) else $error("enable kept");
	chk_ack_phase: assert property (irq_ack |-> $past(phase_two_pulse)) else $error("off phase");
	chk_ack_global: assert property (irq_ack |-> $past(global_irq_enable)) else $error("masked");
	chk_stack_block: assert property (irq_ack |-> !$past(stack_full)) else $error("stack full");
	chk_vec_hold: assert property (!irq_ack |-> $stable(irq_vector)) else $error("vector moved");
	chk_vec_legal: assert property (irq_ack |-> irq_vector inside {8'h04, 8'h08, 8'h0C, 8'h10,
		8'h14, 8'h18}) else $error("bad vector");
	// Register image and global enable
	chk_second_rsvd: assert property ($past(reg_addr) == 8'h1E |-> reg_rdata[3] == 1'b0
		&& !reg_rdata[7]) else $error("reserved set");
	chk_first_image: assert property ($past(reg_addr) == 8'h0B |-> reg_rdata[0] ==
		global_irq_enable && !reg_rdata[7]) else $error("image wrong");
	chk_enable_rise: assert property ($rose(global_irq_enable) |-> $past(reg_wr)
		|| $past(isr_exit_reenable)) else $error("enable rose");
	chk_isr_exit_reenable_sets: assert property (isr_exit_reenable |=> global_irq_enable || irq_ack)
		else $error("return ignored");
	cover property (irq_ack && irq_vector == 8'h18);
	cover property (stack_full && global_irq_enable && phase_two_pulse);
	cover property ($rose(global_irq_enable) && $past(isr_exit_reenable));
endmodule
bind svi_irq_unit svi_irq_checker u_svi_irq_checker (.mclk, .reset, .phase_two_pulse,
	.stack_full, .isr_exit_reenable, .reg_wr, .reg_addr, .reg_rdata, .irq_ack, .irq_vector,
	.global_irq_enable);

//--- tb/svi_core_model.sv
// Core sequencer model: phase pulses and service routine returns
`timescale 1ns/1ns
module svi_core_model #(parameter int SVC_LEN = 6) (
	input  wire logic mclk,             // Clock
	input  wire logic reset,            // Sync reset
	input  wire logic irq_ack,          // Acknowledge from the unit
	output logic      phase_two_pulse,  // One clock in four
	output logic      isr_exit_reenable // Return with re-enable
);
	logic [1:0] phase_q = 2'h0;
	int         svc_q = 0;
	initial phase_two_pulse = 1'b0;
	initial isr_exit_reenable = 1'b0;
	// Four-clock instruction cycle, phase two on its last clock
	always @(posedge mclk) begin
		phase_q <= reset ? 2'h0 : phase_q + 2'h1;
		phase_two_pulse <= !reset && phase_q == 2'h2;
	end
	// Routine makes no nested call, so one free level is never at risk
	always @(posedge mclk) begin
		svc_q <= reset ? 0 : (irq_ack ? SVC_LEN : (svc_q > 0 ? svc_q - 1 : 0));
		isr_exit_reenable <= !reset && svc_q == 1;
	end
endmodule

//--- tb/tb_svi_irq_unit.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ns
module tb_svi_irq_unit;
	logic       mclk = 1'b0, reset = 1'b1, ext_irq_pin_zero = 1'b1, ext_irq_pin_one = 1'b1;
	logic       tmr0_overflow = 1'b0, tmr1_overflow = 1'b0, tick_base_pulse = 1'b0;
	logic       clock_tick_pulse = 1'b0, stack_full = 1'b0, plain_subroutine_exit = 1'b0;
	logic       reg_wr = 1'b0, phase_two_pulse, isr_exit_reenable, irq_ack, global_irq_enable;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, irq_vector;
	logic [7:0] exp_q[$];
	logic [15:0] rnd = 16'h0010;
	logic [5:0] s;
	int         err_count = 0, total_checks = 0;
	always #10 mclk = ~mclk;
	svi_irq_unit u_svi_irq_unit (.mclk, .reset, .phase_two_pulse, .ext_irq_pin_zero,
		.ext_irq_pin_one, .tmr0_overflow, .tmr1_overflow, .tick_base_pulse, .clock_tick_pulse,
		.stack_full, .isr_exit_reenable, .plain_subroutine_exit, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rdata, .irq_ack, .irq_vector, .global_irq_enable);
	svi_core_model #(.SVC_LEN(6)) u_svi_core_model (.mclk, .reset, .irq_ack, .phase_two_pulse,
		.isr_exit_reenable);
	function automatic logic [15:0] xs(input logic [15:0] x);
		x = x ^ (x << 7);
		x = x ^ (x >> 9);
		return x ^ (x << 8);
	endfunction
	task automatic step(input int n = 1);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			err_count++;
			$display("Error at %0t: saw %h, want %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
		step();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		reg_addr = a;
		step();
		check(reg_rdata, want);
	endtask
	// Pins fall for one clock; timer and tick events pulse for one
	task automatic fire(input logic [5:0] v);
		{clock_tick_pulse, tick_base_pulse, tmr1_overflow, tmr0_overflow, ext_irq_pin_one,
			ext_irq_pin_zero} = v ^ 6'h03;
		step();
		{clock_tick_pulse, tick_base_pulse, tmr1_overflow, tmr0_overflow, ext_irq_pin_one,
			ext_irq_pin_zero} = 6'h03;
	endtask
	// Bounded wait for all expected acks, then room for returns and stray acks
	task automatic drain();
		for (int i = 0; i < 400 && exp_q.size() > 0; i++) step();
		step(12);
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Each acknowledge takes the oldest expected vector; a stray one fails
	// Looked at on the falling edge, where the registered outputs have settled
	always @(negedge mclk) begin
		if (irq_ack === 1'b1) begin
			check(irq_vector, exp_q.size() > 0 ? exp_q.pop_front() : 8'hFF);
		end
	end
	// Run needs under 1500 clocks; this limit only cuts a hang
	initial begin
		#100000;
		err_count++;
		test_done();
	end
	initial begin
		step(3);
		reset = 1'b0;
		rd(8'h0B, 8'h00);
		rd(8'h1E, 8'h00);
		wr(8'h0B, 8'hF0);
		rd(8'h0B, 8'h70);
		wr(8'h0B, 8'h00);
		plain_subroutine_exit = 1'b1;
		step();
		plain_subroutine_exit = 1'b0;
		rd(8'h0B, 8'h00);
		rnd = xs(rnd);
		wr(8'h1E, rnd[7:0]);
		rd(8'h1E, rnd[7:0] & 8'h77);
		// Source groups gathered under a closed global enable, then served by priority
		wr(8'h1E, 8'h07);
		for (int k = 0; k < 5; k++) begin
			rnd = xs(rnd);
			s = (k == 0) ? 6'h3F : rnd[5:0];
			wr(8'h0B, 8'h0E);
			fire(s);
			step(6);
			rd(8'h0B, {1'b0, s[2:0], 4'hE});
			rd(8'h1E, {1'b0, s[5:3], 4'h7});
			for (int i = 0; i < 6; i++) begin
				if (s[i]) exp_q.push_back(8'(4 * i + 4));
			end
			wr(8'h0B, {1'b0, s[2:0], 4'hF});
			drain();
			rd(8'h0B, 8'h0F);
		end
		// A disabled source records but waits for its enable
		wr(8'h0B, 8'h01);
		fire(6'h04);
		step(20);
		rd(8'h0B, 8'h41);
		exp_q.push_back(8'h0C);
		wr(8'h0B, 8'h49);
		drain();
		// A full stack holds an enabled request until a level frees
		stack_full = 1'b1;
		wr(8'h0B, 8'h01);
		wr(8'h1E, 8'h11);
		step(20);
		exp_q.push_back(8'h10);
		stack_full = 1'b0;
		drain();
		check(8'(exp_q.size()), 8'h00);
		test_done();
	end
endmodule
